// [rtl/lrrw_cfg.svh]
// Named constants for the log record retrieval window block.
// Assumes word-addressed register numbers as seen by the link master.
`ifndef LRRW_CFG_SVH
`define LRRW_CFG_SVH

`define LRRW_A_START_HI   16'h0601
`define LRRW_A_START_LO   16'h0602
`define LRRW_A_COUNT      16'h0603
`define LRRW_A_WIN_FIRST  16'h0604
`define LRRW_A_WIN_LAST   16'h067b
`define LRRW_A_MAXREC_HI  16'h0700
`define LRRW_A_MAXREC_LO  16'h0701
`define LRRW_A_USED_HI    16'h0702
`define LRRW_A_USED_LO    16'h0703
`define LRRW_A_WIN_MAX    16'h0704
`define LRRW_A_NEWEST_HI  16'h0705
`define LRRW_A_NEWEST_LO  16'h0706
`define LRRW_A_OLDEST_HI  16'h0707
`define LRRW_A_OLDEST_LO  16'h0708
`define LRRW_A_NEW_TS     16'h0709
`define LRRW_A_OLD_TS     16'h070c
`define LRRW_A_MEMSTAT    16'h070f

`define LRRW_TS_WORDS     8'h03
`define LRRW_ST_BADREQ    8'hfd
`define LRRW_ST_ERASING   8'hfe
`define LRRW_ST_STALE     8'hff
`define LRRW_ST_ERASED    8'h00

`define LRRW_WIN_BYTES    240
`define LRRW_TIME_BYTES   6
`define LRRW_PARAM_BYTES  4
`define LRRW_WORD_BYTES   2
`define LRRW_FIRST_SERIAL 32'h0000_0001
`define LRRW_START_RESET  32'h0000_0001
`define LRRW_COUNT_RESET  8'h00

`endif

// [rtl/lrrw_pkg.sv]
// Types shared by the log record retrieval window block.
// Assumes nothing of its surroundings.
package lrrw_pkg;

  typedef struct packed {
    logic        valid;
    logic        from_mem;
    logic [15:0] value;
  } lrrw_rd_stage_t;

  typedef struct packed {
    logic        hit;
    logic [7:0]  rec;
    logic [7:0]  word;
  } lrrw_win_pos_t;

endpackage

// [rtl/lrrw_mem.sv]
// Record store: one write port, one read port with registered data.
// Assumes a single clock shared with the retrieval logic.
`timescale 1ns/1ps
module lrrw_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= store[rd_addr];
    end
  end

endmodule // lrrw_mem

// [rtl/lrrw_top.sv]
// Retrieval window over a circular store of timestamped log records.
// Assumes a word register port driven by a link front end on SYS_CLK,
// log words from on-chip logic on SYS_CLK, and an async erase-busy pin.
`timescale 1ns/1ps
`include "lrrw_cfg.svh"
module lrrw_top #(
  parameter int N_PARAMS  = 13,
  parameter int SLOT_BITS = 4
) (
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        REG_RD,
  input  wire logic        REG_WR,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        LOG_VALID,
  input  wire logic [15:0] LOG_WORD,
  input  wire logic        ERASE_BUSY,
  output logic      [15:0] REG_RDATA,
  output logic             REG_RVALID
);

  // record layout in bytes and words
  localparam int REC_BYTES = `LRRW_TIME_BYTES
                           + `LRRW_PARAM_BYTES * N_PARAMS;
  localparam int REC_WORDS = REC_BYTES / `LRRW_WORD_BYTES;
  localparam int WIN_MAX   = `LRRW_WIN_BYTES / REC_BYTES;
  localparam int SLOTS     = 2 ** SLOT_BITS;
  localparam int MEM_WORDS = SLOTS * REC_WORDS;
  localparam int MEM_AW    = $clog2(MEM_WORDS);
  localparam int UW        = SLOT_BITS + 1;

  localparam logic [7:0]        WIN_MAX8  = 8'(WIN_MAX);
  localparam logic [7:0]        REC_W8    = 8'(REC_WORDS);
  localparam logic [31:0]       SLOTS32   = 32'(SLOTS);
  localparam logic [UW-1:0]     SLOTS_U   = UW'(SLOTS);
  localparam logic [MEM_AW-1:0] MEM_LAST  = MEM_AW'(MEM_WORDS - 1);

  logic                   erase_meta;
  logic                   erase_busy;
  logic [31:0]            newest;
  logic [UW-1:0]          used;
  logic [31:0]            oldest;
  logic [MEM_AW-1:0]      wr_addr;
  logic [7:0]             word_idx;
  logic [31:0]            start;
  logic [7:0]             count;
  logic                   stale;
  logic                   req_wr;
  logic [7:0]             outcome;
  logic [7:0]             next_outcome;
  logic [31:0]            avail;
  logic                   outcome_ok;
  logic [15:0]            win_off;
  lrrw_pkg::lrrw_win_pos_t win;
  logic                   win_valid;
  logic                   advance;
  logic [31:0]            advanced;
  logic                   log_take;
  logic                   rec_last;
  logic [MEM_AW-1:0]      mem_raddr;
  logic [15:0]            mem_q;
  lrrw_pkg::lrrw_rd_stage_t next_rd;
  lrrw_pkg::lrrw_rd_stage_t rd_stage;

  // Slot of a serial and word inside it, in store words
  function automatic logic [MEM_AW-1:0] rec_addr(
    input logic [31:0] serial,
    input logic [7:0]  word
  );
    logic [31:0] slot;
    slot     = (serial - `LRRW_FIRST_SERIAL) & (SLOTS32 - 32'h1);
    rec_addr = MEM_AW'(slot * 32'(REC_WORDS) + 32'(word));
  endfunction

  // Word address inside a span of consecutive registers
  function automatic logic in_span(
    input logic [15:0] addr,
    input logic [15:0] first,
    input logic [15:0] words
  );
    in_span = (addr >= first) && (addr < first + words);
  endfunction

  // Erase-busy pin synchroniser
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      erase_meta <= 1'b0;
      erase_busy <= 1'b0;
    end else begin
      erase_meta <= ERASE_BUSY;
      erase_busy <= erase_meta;
    end
  end

  assign log_take = LOG_VALID && !erase_busy;
  assign rec_last = (word_idx == REC_W8 - 8'h01);

  // write pointer wraps over the oldest slot
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_addr  <= '0;
      word_idx <= 8'h00;
    end else if (erase_busy) begin
      // Drop a half-written record so slots stay record-aligned
      wr_addr  <= wr_addr - MEM_AW'(word_idx);
      word_idx <= 8'h00;
    end else if (log_take) begin
      word_idx <= rec_last ? 8'h00 : word_idx + 8'h01;
      wr_addr  <= (wr_addr == MEM_LAST) ? '0 : wr_addr + MEM_AW'(1);
    end
  end

  // serial advances by one per committed record
  // no restart on overwrite or erase
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      newest <= `LRRW_FIRST_SERIAL - 32'h1;
    end else if (log_take && rec_last) begin
      newest <= newest + 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      used <= '0;
    end else if (erase_busy) begin
      used <= '0;
    end else if (log_take && rec_last) begin
      if (used != SLOTS_U) begin
        used <= used + UW'(1);
      end
    end else if (log_take && word_idx == 8'h00 && used == SLOTS_U) begin
      // slot being overwritten leaves the store
      used <= used - UW'(1);
    end
  end

  assign oldest = newest + 32'h1 - 32'(used);

  // window position split into whole records
  assign win_off  = REG_ADDR - `LRRW_A_WIN_FIRST;
  assign win.hit  = (REG_ADDR >= `LRRW_A_WIN_FIRST)
                 && (REG_ADDR <= `LRRW_A_WIN_LAST);
  assign win.rec  = 8'(win_off / 16'(REC_WORDS));
  assign win.word = 8'(win_off % 16'(REC_WORDS));

  // Window decode follows the live status, so a read just after an
  // advance or a request write never sees the old window's count
  assign outcome_ok = (next_outcome <= WIN_MAX8);
  assign win_valid  = win.hit && outcome_ok && (win.rec < next_outcome);
  assign advanced   = start + 32'(next_outcome);
  // last word of the last valid record consumes the window
  assign advance    = REG_RD && win.hit && outcome_ok
                   && (next_outcome != 8'h00)
                   && (win_off == 16'(next_outcome) * 16'(REC_WORDS) - 16'h1);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      start <= `LRRW_START_RESET;
    end else if (REG_WR && REG_ADDR == `LRRW_A_START_HI) begin
      start[31:16] <= REG_WDATA;
    end else if (REG_WR && REG_ADDR == `LRRW_A_START_LO) begin
      start[15:0] <= REG_WDATA;
    end else if (advance) begin
      if (advanced > newest) begin
        start <= newest + 32'h1;
      end else begin
        start <= advanced;
      end
    end
  end

  // only the high byte is taken
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      count <= `LRRW_COUNT_RESET;
    end else if (REG_WR && REG_ADDR == `LRRW_A_COUNT) begin
      count <= REG_WDATA[15:8];
    end
  end

  assign req_wr = REG_WR && (REG_ADDR == `LRRW_A_START_HI
                          || REG_ADDR == `LRRW_A_START_LO
                          || REG_ADDR == `LRRW_A_COUNT);

  // any request write makes the window current
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      stale <= 1'b1;
    end else if (req_wr) begin
      stale <= 1'b0;
    end
  end

  assign avail = newest + 32'h1 - start;

  always_comb begin
    next_outcome = `LRRW_ST_STALE;
    if (erase_busy) begin
      next_outcome = `LRRW_ST_ERASING;
    end else if (stale) begin
      next_outcome = `LRRW_ST_STALE;
    end else if (count == 8'h00 || count > WIN_MAX8
              || start < oldest || start > newest + 32'h1) begin
      next_outcome = `LRRW_ST_BADREQ;
    end else if (avail < 32'(count)) begin
      next_outcome = 8'(avail);
    end else begin
      next_outcome = count;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      outcome <= `LRRW_ST_STALE;
    end else begin
      outcome <= next_outcome;
    end
  end

  always_comb begin
    next_rd       = '0;
    next_rd.valid = REG_RD;
    mem_raddr     = '0;
    if (win.hit) begin
      // positions without a valid record read zero
      if (win_valid) begin
        next_rd.from_mem = 1'b1;
        mem_raddr = rec_addr(start + 32'(win.rec), win.word);
      end
    end else if (REG_ADDR == `LRRW_A_START_HI) begin
      next_rd.value = start[31:16];
    end else if (REG_ADDR == `LRRW_A_START_LO) begin
      next_rd.value = start[15:0];
    end else if (REG_ADDR == `LRRW_A_COUNT) begin
      next_rd.value = {count, outcome};
    end else if (REG_ADDR == `LRRW_A_MAXREC_HI) begin
      next_rd.value = SLOTS32[31:16];
    end else if (REG_ADDR == `LRRW_A_MAXREC_LO) begin
      next_rd.value = SLOTS32[15:0];
    end else if (REG_ADDR == `LRRW_A_USED_HI) begin
      next_rd.value = 16'h0000;
    end else if (REG_ADDR == `LRRW_A_USED_LO) begin
      next_rd.value = 16'(used);
    end else if (REG_ADDR == `LRRW_A_WIN_MAX) begin
      next_rd.value = 16'(WIN_MAX);
    end else if (REG_ADDR == `LRRW_A_NEWEST_HI) begin
      next_rd.value = newest[31:16];
    end else if (REG_ADDR == `LRRW_A_NEWEST_LO) begin
      next_rd.value = newest[15:0];
    end else if (REG_ADDR == `LRRW_A_OLDEST_HI) begin
      next_rd.value = oldest[31:16];
    end else if (REG_ADDR == `LRRW_A_OLDEST_LO) begin
      next_rd.value = oldest[15:0];
    end else if (in_span(REG_ADDR, `LRRW_A_NEW_TS, 16'(`LRRW_TS_WORDS))) begin
      // newest time mark from the store
      next_rd.from_mem = (used != '0);
      mem_raddr = rec_addr(newest, 8'(REG_ADDR - `LRRW_A_NEW_TS));
    end else if (in_span(REG_ADDR, `LRRW_A_OLD_TS, 16'(`LRRW_TS_WORDS))) begin
      // oldest time mark from the store
      next_rd.from_mem = (used != '0);
      mem_raddr = rec_addr(oldest, 8'(REG_ADDR - `LRRW_A_OLD_TS));
    end else if (REG_ADDR == `LRRW_A_MEMSTAT) begin
      // erase progress in the low byte
      next_rd.value = {8'h00, erase_busy ? `LRRW_ST_ERASING
                                         : `LRRW_ST_ERASED};
    end
  end

  lrrw_mem #(
    .WIDTH (16),
    .DEPTH (MEM_WORDS),
    .AW    (MEM_AW)
  ) u_mem (
    .clk     (SYS_CLK),
    .rst_n   (NRST),
    .wr_en   (log_take),
    .wr_addr (wr_addr),
    .wr_data (LOG_WORD),
    .rd_addr (mem_raddr),
    .rd_data (mem_q)
  );

  // Read select stage, lined up with the store's registered data
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_stage <= '0;
    end else begin
      rd_stage <= next_rd;
    end
  end

  // Answer pulse, one cycle per taken read
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= rd_stage.valid;
    end
  end

  // Answer data holds until the next answer
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 16'h0000;
    end else if (rd_stage.valid) begin
      REG_RDATA <= rd_stage.from_mem ? mem_q : rd_stage.value;
    end
  end

endmodule // lrrw_top

// [test/lrrw_top_sva.sv]
// Port checker for the retrieval window top module.
// Assumes reads answer two cycles after the taking edge.
`timescale 1ns/1ps
module lrrw_top_chk #(
  parameter int N_PARAMS  = 13,
  parameter int SLOT_BITS = 4
) (
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        REG_RD,
  input wire logic        REG_WR,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        LOG_VALID,
  input wire logic [15:0] LOG_WORD,
  input wire logic        ERASE_BUSY,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_RVALID
);
  localparam int WMAX = 240 / (6 + 4 * N_PARAMS);
  localparam int SLOTS = 2 ** SLOT_BITS;
  logic unmapped;
  assign unmapped = REG_ADDR < 16'h0601 || REG_ADDR > 16'h070f ||
                    (REG_ADDR > 16'h067b && REG_ADDR < 16'h0700);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_rd_latency: assert property (REG_RD |-> ##2 REG_RVALID)
    else $error("read not answered after two cycles");
  a_rvalid_cause: assert property (REG_RVALID |-> $past(REG_RD, 2))
    else $error("answer without a read");
  a_rdata_hold: assert property (!REG_RVALID |-> $stable(REG_RDATA))
    else $error("read data moved between answers");
  a_reset_clear: assert property ($rose(NRST) |-> REG_RDATA == 16'h0000
    && !REG_RVALID) else $error("port not clear after reset");
  a_winmax_value: assert property (REG_RD && REG_ADDR == 16'h0704 |-> ##2
    REG_RDATA == 16'(WMAX)) else $error("window maximum wrong");
  a_unmapped_zero: assert property (REG_RD && unmapped |-> ##2
    REG_RDATA == 16'h0000) else $error("unmapped read not zero");
  a_erase_flag: assert property (ERASE_BUSY [*5] ##0
    (REG_RD && REG_ADDR == 16'h070f) |-> ##2 REG_RDATA[7:0] == 8'hfe)
    else $error("memory status not erasing");
  a_idle_memstat: assert property (!ERASE_BUSY [*5] ##0
    (REG_RD && REG_ADDR == 16'h070f) |-> ##2 REG_RDATA[7:0] == 8'h00)
    else $error("memory status not idle");
  a_erase_status: assert property (ERASE_BUSY [*5] ##0
    (REG_RD && REG_ADDR == 16'h0603) |-> ##2 REG_RDATA[7:0] == 8'hfe)
    else $error("status not erasing code");
  a_status_range: assert property (REG_RD && REG_ADDR == 16'h0603 |-> ##2
    (REG_RDATA[7:0] <= 8'(WMAX) || REG_RDATA[7:0] >= 8'hfd))
    else $error("status outside count or codes");
  a_capacity_value: assert property (REG_RD && REG_ADDR == 16'h0701 |-> ##2
    REG_RDATA == 16'(SLOTS)) else $error("capacity wrong");
  a_used_bound: assert property (REG_RD && REG_ADDR == 16'h0703 |-> ##2
    REG_RDATA <= 16'(SLOTS)) else $error("used count above capacity");
  c_win_read: cover property (REG_RD && REG_ADDR == 16'h0604 ##2 REG_RVALID);
  c_erase: cover property (ERASE_BUSY [*5] ##0 REG_RD);
  c_count_write: cover property (REG_WR && REG_ADDR == 16'h0603);
endmodule // lrrw_top_chk

// [test/lrrw_master_model.sv]
// Link master model driving the retrieval window register port.
// Assumes one-cycle request pulses and a one-cycle answer pulse.
`timescale 1ns/1ps
module lrrw_master_model (
  input  wire logic        clk,
  input  wire logic        rvalid,
  input  wire logic [15:0] rdata,
  output logic             rd,
  output logic             wr,
  output logic      [15:0] addr,
  output logic      [15:0] wdata
);
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
  end
  task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask
  task automatic rd_word(input logic [15:0] a, output logic [15:0] d,
                         output logic ok);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk);
      if (rvalid === 1'b1) begin
        d = rdata;
        ok = 1'b1;
      end
    end
  endtask
  // start then count, low byte junk
  task automatic set_req(input logic [31:0] s, input logic [7:0] n);
    wr_word(16'h0601, s[31:16]);
    wr_word(16'h0602, s[15:0]);
    wr_word(16'h0603, {n, 8'h55});
  endtask
  // window kept only on a record count
  task automatic win_usable(input logic [7:0] wmax, output logic keep,
                            output logic ok);
    logic [15:0] d;
    rd_word(16'h0603, d, ok);
    keep = ok && (d[7:0] <= wmax);
  endtask
endmodule // lrrw_master_model

// [test/test_log_record_retrieval_window.sv]
// Self-checking bench for the retrieval window top module.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/1ps
module test_log_record_retrieval_window;
  localparam int NP = 1;
  logic        SYS_CLK, NRST, REG_RD, REG_WR, LOG_VALID, ERASE_BUSY;
  logic        REG_RVALID;
  logic [15:0] REG_ADDR, REG_WDATA, LOG_WORD, REG_RDATA;
  int          fails = 0;
  int          cmp_count = 0;
  lrrw_top #(.N_PARAMS(NP), .SLOT_BITS(2)) u_dut (.SYS_CLK(SYS_CLK),
    .NRST(NRST), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .LOG_VALID(LOG_VALID), .LOG_WORD(LOG_WORD),
    .ERASE_BUSY(ERASE_BUSY), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));
  lrrw_master_model u_master (.clk(SYS_CLK), .rvalid(REG_RVALID),
    .rdata(REG_RDATA), .rd(REG_RD), .wr(REG_WR), .addr(REG_ADDR),
    .wdata(REG_WDATA));
  always #2.5 SYS_CLK = ~SYS_CLK;
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    u_master.rd_word(a, d, ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] answer %h exp %h got none", a, e);
      tally_and_finish();
    end else if (d !== e) begin
      fails++;
      $display("[ERR] reg %h exp %h got %h", a, e, d);
    end
  endtask
  task automatic keep_chk(input logic e);
    logic keep;
    logic ok;
    u_master.win_usable(8'h18, keep, ok);
    cmp_count++;
    if (ok !== 1'b1 || keep !== e) begin
      fails++;
      $display("[ERR] keep window exp %b got %b", e, keep);
    end
  endtask
  // Word w of record s carries s in its upper nibbles
  task automatic log_rec(input int s);
    for (int w = 0; w < 3 + 2 * NP; w++) begin
      @(negedge SYS_CLK);
      LOG_VALID = 1'b1;
      LOG_WORD = 16'(s * 16 + w);
    end
    @(negedge SYS_CLK);
    LOG_VALID = 1'b0;
    LOG_WORD = 16'hffff;
  endtask
  task automatic t_idle();
    rd_chk(16'h0603, 16'h00ff);
    rd_chk(16'h0704, 16'h0018);
    rd_chk(16'h0701, 16'h0004);
    rd_chk(16'h0703, 16'h0000);
    rd_chk(16'h070f, 16'h0000);
    rd_chk(16'h0600, 16'h0000);
    $display("Test idle done");
  endtask
  task automatic t_serials();
    for (int s = 1; s <= 6; s++)
      log_rec(s);
    rd_chk(16'h0706, 16'h0006);
    rd_chk(16'h0705, 16'h0000);
    rd_chk(16'h0708, 16'h0003);
    rd_chk(16'h0703, 16'h0004);
    rd_chk(16'h070c, 16'h0030);
    rd_chk(16'h070b, 16'h0062);
    $display("Test serials done");
  endtask
  task automatic t_window();
    u_master.set_req(32'h3, 8'h02);
    rd_chk(16'h0603, 16'h0202);
    keep_chk(1'b1);
    for (int k = 0; k < 9; k++)
      rd_chk(16'(16'h0604 + k), 16'((3 + k / 5) * 16 + k % 5));
    rd_chk(16'h060e, 16'h0000);
    rd_chk(16'h060d, 16'h0044);
    rd_chk(16'h0602, 16'h0005);
    $display("Test window done");
  endtask
  task automatic t_clamp();
    u_master.set_req(32'h5, 8'h04);
    rd_chk(16'h0603, 16'h0402);
    rd_chk(16'h060d, 16'h0064);
    rd_chk(16'h0602, 16'h0007);
    rd_chk(16'h0601, 16'h0000);
    rd_chk(16'h0603, 16'h0400);
    $display("Test clamp done");
  endtask
  task automatic t_bad();
    logic [31:0] st [4] = '{32'h3, 32'h3, 32'h2, 32'h8};
    logic [7:0]  ct [4] = '{8'h00, 8'h19, 8'h02, 8'h02};
    for (int i = 0; i < 4; i++) begin
      u_master.set_req(st[i], ct[i]);
      rd_chk(16'h0603, {ct[i], 8'hfd});
      keep_chk(1'b0);
    end
    $display("Test refusal done");
  endtask
  task automatic t_erase();
    @(negedge SYS_CLK);
    ERASE_BUSY = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    rd_chk(16'h0603, 16'h02fe);
    keep_chk(1'b0);
    rd_chk(16'h070f, 16'h00fe);
    log_rec(9);
    ERASE_BUSY = 1'b0;
    repeat (6) @(negedge SYS_CLK);
    rd_chk(16'h070f, 16'h0000);
    rd_chk(16'h0703, 16'h0000);
    log_rec(7);
    rd_chk(16'h0706, 16'h0007);
    rd_chk(16'h0708, 16'h0007);
    rd_chk(16'h0703, 16'h0001);
    $display("Test erase done");
  endtask
  task automatic t_reset();
    @(negedge SYS_CLK);
    NRST = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    NRST = 1'b1;
    rd_chk(16'h0603, 16'h00ff);
    rd_chk(16'h0602, 16'h0001);
    rd_chk(16'h0706, 16'h0000);
    log_rec(1);
    rd_chk(16'h0706, 16'h0001);
    rd_chk(16'h0708, 16'h0001);
    rd_chk(16'h070c, 16'h0010);
    $display("Test reset done");
  endtask
  initial begin
    SYS_CLK = 1'b0;
    NRST = 1'b0;
    LOG_VALID = 1'b0;
    LOG_WORD = 16'h0000;
    ERASE_BUSY = 1'b0;
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    NRST = 1'b1;
    t_idle();
    t_serials();
    t_window();
    t_clamp();
    t_bad();
    t_erase();
    t_reset();
    tally_and_finish();
  end
endmodule // test_log_record_retrieval_window
bind lrrw_top lrrw_top_chk #(.N_PARAMS(N_PARAMS), .SLOT_BITS(SLOT_BITS))
  u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .REG_RD(REG_RD), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .LOG_VALID(LOG_VALID),
  .LOG_WORD(LOG_WORD), .ERASE_BUSY(ERASE_BUSY), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID));
